// file: rtl/ste_ctrl_pkg.sv
// constants for the stream entry control slice decoder
package ste_ctrl_pkg;
   localparam int SCRATCH_LO      = 84;
   localparam int SCRATCH_HI      = 87;
   localparam int PIE_BIT         = 88;
   localparam int FWB_BIT         = 89;
   localparam int PART_SRC_BIT    = 90;
   localparam int STALLD_BIT      = 91;
   localparam int TSE_LO          = 92;
   localparam int TSE_HI          = 93;
   localparam int ENTRY_W         = 128;
   localparam logic [1:0] TSE_OFF   = 2'h0;
   localparam logic [1:0] TSE_FULL  = 2'h1;
   localparam logic [1:0] TSE_SPLIT = 2'h2;
   localparam logic [1:0] TSE_CHECK = 2'h3;
   localparam logic [2:0] CFG_ABORT  = 3'h0;
   localparam logic [2:0] CFG_BYPASS = 3'h4;
   localparam logic [2:0] CFG_NESTED = 3'h7;
   localparam logic [1:0] STALL_NONE = 2'h0;
   localparam logic [1:0] STALL_CFG  = 2'h0;
   localparam logic       RST_VALID  = 1'b0;
endpackage

// file: rtl/ste_ctrl_tse.sv
// translation service enable resolution for one entry
`timescale 1ns/1ps
module ste_ctrl_tse
   import ste_ctrl_pkg::*;
(
   // entry fields
   input  wire logic [1:0] tse_raw,
   input  wire logic [2:0] config_val,
   input  wire logic       stage2_stall_bit,
   input  wire logic       secure_entry,
   input  wire logic       world_is_el1,
   // capabilities and control
   input  wire logic       service_cap,
   input  wire logic       no_stage1_service_cap,
   input  wire logic       per_granule_check_cap,
   input  wire logic       translated_traffic_check,
   // results
   output logic [1:0]      tse_eff,
   output logic            tse_illegal,
   output logic            tse_silent
);
   logic ignored;
   logic s2_on;

   always_comb begin
      ignored     = !service_cap || (config_val[1:0] == 2'h0)
                    || secure_entry;                       // see R20, R21
      s2_on       = config_val[2] && config_val[1];
      tse_eff     = TSE_OFF;
      tse_illegal = 1'b0;
      tse_silent  = !ignored ? 1'b0 : (config_val == CFG_ABORT); // see R21
      if (!ignored) begin
         unique case (tse_raw)
            TSE_OFF: begin
               tse_eff = TSE_OFF;                          // see R11
            end
            TSE_FULL: begin
               tse_illegal = s2_on && stage2_stall_bit;    // see R13
               tse_eff     = TSE_FULL;                     // see R12
            end
            TSE_SPLIT: begin
               tse_illegal = (config_val != CFG_NESTED) || stage2_stall_bit
                             || no_stage1_service_cap;     // see R15
               // check off behaves as disabled
               tse_eff = translated_traffic_check ? TSE_SPLIT
                                                  : TSE_OFF; // see R14, R16
            end
            TSE_CHECK: begin
               if (!per_granule_check_cap) begin
                  tse_eff = TSE_OFF;                       // see R19
               end else if (!world_is_el1) begin
                  tse_illegal = 1'b1;                      // see R18
               end else begin
                  tse_illegal = s2_on && stage2_stall_bit;
                  tse_eff = translated_traffic_check ? TSE_CHECK
                                                     : TSE_OFF; // see R17, R19
               end
            end
         endcase
      end
   end
endmodule

// file: rtl/ste_ctrl_decode.sv
// stream entry control slice decoder, bits 84 to 93
`timescale 1ns/1ps
// Summary of operation
// R1 - software scratch bits 87:84 never affect any output.
// R2 - permission indirection allowed only when bit 88 set.
// R3 - forced writeback bit 89 selects direct stage 2 memory type.
// R4 - forced writeback effective only when stage 2 is performed.
// R5 - forced writeback with 32-bit stage 2 format is illegal.
// R6 - bit 90 selects descriptor identifiers with remap when stage 1 on.
// R7 - without stage 1, entry's own identifiers are used.
// R8 - stall disable bit 91 forbids stage 1 stall mode.
// R9 - stall disable ignored without stage 1; illegal unless configurable.
// R10 - software sets stall disable for stall-unsafe or pcie streams.
// R11 - enable 00: requests UR, bad request event; checked traffic aborted.
// R12 - enable 01: requests serviced, translated traffic bypasses.
// R13 - enable 01 illegal with stage 2 and stage 2 stall bit.
// R14 - enable 10: responses give stage 1 output, traffic gets stage 2.
// R15 - enable 10 illegal unless nested, no stall, no no-stage1 cap.
// R16 - legal enable 10 with check off behaves as 00.
// R17 - legal enable 11 is 01 plus per-granule checks.
// R18 - enable 11 illegal when capability present and world not EL1.
// R19 - enable 11 treated as 00 without capability or check off.
// R20 - secure entries always have effective enable 00.
// R21 - enable ignored without service or config 1:0 zero; 000 silent.
// R22 - requests always checked; translated traffic checked only if check on.
// R23 - effective values and illegal flag registered once per lookup.
// R24 - after reset no valid output and no illegal flag.
module ste_ctrl_decode
   import ste_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // lookup
   input  wire logic               lookup_valid,
   input  wire logic [ENTRY_W-1:0] stream_table_entry,
   input  wire logic [2:0]         config_val,
   input  wire logic               substream_bypass,
   input  wire logic               stage2_stall_bit,
   input  wire logic               stage2_table_format_sel,
   input  wire logic               secure_entry,
   input  wire logic               world_is_el1,
   // capabilities
   input  wire logic               perm_indirect_cap,
   input  wire logic [1:0]         stall_model_cap,
   input  wire logic               service_cap,
   input  wire logic               no_stage1_service_cap,
   input  wire logic               per_granule_check_cap,
   // global control
   input  wire logic               translated_traffic_check,
   // request kind of this lookup
   input  wire logic               is_trans_request,
   input  wire logic               is_translated_traffic,
   // decoded results
   output logic                    decode_valid,
   output logic                    bad_entry_error,
   output logic                    stage1_perm_indirect_en,
   output logic                    stage2_forced_writeback,
   output logic                    partition_from_descriptor,
   output logic                    stage1_stall_disable,
   output logic [1:0]              translation_service_enable,
   output logic                    request_unsupported,
   output logic                    bad_request_event,
   output logic                    traffic_abort,
   output logic                    forbidden_translation_event,
   output logic                    traffic_bypass
);
   // ------------------------------------------------------------
   // combinational decode
   // ------------------------------------------------------------
   logic [1:0] tse_eff;
   logic       tse_illegal;
   logic       tse_silent;
   logic       s1_on;
   logic       s2_on;
   logic       fwb_eff;
   logic       pie_eff;
   logic       part_eff;
   logic       stalld_eff;
   logic       illegal_c;
   logic       req_ur_c;
   logic       bad_req_c;
   logic       abort_c;
   logic       forbid_c;
   logic       bypass_c;
   logic       tse_live;

   ste_ctrl_tse u_tse (
      .tse_raw                  (stream_table_entry[TSE_HI:TSE_LO]),
      .config_val               (config_val),
      .stage2_stall_bit         (stage2_stall_bit),
      .secure_entry             (secure_entry),
      .world_is_el1             (world_is_el1),
      .service_cap              (service_cap),
      .no_stage1_service_cap    (no_stage1_service_cap),
      .per_granule_check_cap    (per_granule_check_cap),
      .translated_traffic_check (translated_traffic_check),
      .tse_eff                  (tse_eff),
      .tse_illegal              (tse_illegal),
      .tse_silent               (tse_silent)
   );

   // scratch bits 87:84 are never read here, see R1
   always_comb begin
      s1_on      = config_val[2] && config_val[0] && !substream_bypass;
      s2_on      = config_val[2] && config_val[1];
      // enable field not ignored, only read by the checks
      tse_live   = service_cap && !secure_entry
                   && (config_val[1:0] != 2'h0);             // see R21
      fwb_eff    = s2_on && stream_table_entry[FWB_BIT];      // see R3, R4
      pie_eff    = perm_indirect_cap && s1_on
                   && stream_table_entry[PIE_BIT];           // see R2
      part_eff   = s1_on && stream_table_entry[PART_SRC_BIT]; // see R6, R7
      stalld_eff = s1_on && stream_table_entry[STALLD_BIT];  // see R8
      illegal_c  = tse_illegal
                   || (fwb_eff && !stage2_table_format_sel)  // see R5
                   || (stalld_eff
                       && (stall_model_cap != STALL_NONE));  // see R9
      // requests always check the effective value, see R22
      req_ur_c   = is_trans_request && (tse_eff == TSE_OFF);  // see R11
      bad_req_c  = req_ur_c && !tse_silent;
      abort_c    = is_translated_traffic && translated_traffic_check
                   && (tse_eff == TSE_OFF);                  // see R11, R22
      forbid_c   = abort_c && !tse_silent;                   // see R21
      // split traffic takes stage 2 here, so it never bypasses
      bypass_c   = is_translated_traffic && !abort_c
                   && (tse_eff != TSE_SPLIT);          // see R12, R14, R22
   end

   // ------------------------------------------------------------
   // result registers, one update per lookup
   // ------------------------------------------------------------
   logic       valid_reg,  valid_next;
   logic       illegal_reg, illegal_next;
   logic [3:0] flags_reg,  flags_next;
   logic [1:0] tse_reg,    tse_next;
   logic [4:0] ev_reg,     ev_next;

   always_comb begin
      valid_next   = lookup_valid;                           // see R23
      illegal_next = illegal_reg;
      flags_next   = flags_reg;
      tse_next     = tse_reg;
      ev_next      = 5'h00;
      if (lookup_valid) begin
         illegal_next = illegal_c;
         flags_next   = {pie_eff, fwb_eff, part_eff, stalld_eff};
         tse_next     = tse_eff;
         // illegal entry reports only the bad entry error
         if (!illegal_c) begin
            ev_next = {req_ur_c, bad_req_c, abort_c, forbid_c, bypass_c};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         valid_reg   <= RST_VALID;                           // see R24
         illegal_reg <= 1'b0;
         flags_reg   <= 4'h0;
         tse_reg     <= 2'h0;
         ev_reg      <= 5'h00;
      end else begin
         valid_reg   <= valid_next;
         illegal_reg <= illegal_next;
         flags_reg   <= flags_next;
         tse_reg     <= tse_next;
         ev_reg      <= ev_next;
      end
   end

   assign decode_valid                = valid_reg;
   assign bad_entry_error             = valid_reg && illegal_reg;
   assign stage1_perm_indirect_en     = flags_reg[3];
   assign stage2_forced_writeback     = flags_reg[2];
   assign partition_from_descriptor   = flags_reg[1];
   assign stage1_stall_disable        = flags_reg[0];
   assign translation_service_enable  = tse_reg;
   assign request_unsupported         = ev_reg[4];
   assign bad_request_event           = ev_reg[3];
   assign traffic_abort               = ev_reg[2];
   assign forbidden_translation_event = ev_reg[1];
   assign traffic_bypass              = ev_reg[0];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_reset_quiet;
      @(posedge clock) $rose(rst_n) |-> !decode_valid && !bad_entry_error;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) // see R24
      else $error("output active after reset");

   property p_one_lookup;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid |=> decode_valid;
   endproperty
   a_one_lookup: assert property (p_one_lookup) // see R23
      else $error("lookup not registered");

   property p_fwb_needs_s2;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && !s2_on |=> !stage2_forced_writeback;
   endproperty
   a_fwb_needs_s2: assert property (p_fwb_needs_s2) // see R4
      else $error("forced writeback without stage 2");

   property p_fwb_format;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && s2_on && stream_table_entry[FWB_BIT]
         && !stage2_table_format_sel |=> bad_entry_error;
   endproperty
   a_fwb_format: assert property (p_fwb_format) // see R5
      else $error("forced writeback format not illegal");

   property p_part_src;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && !s1_on |=> !partition_from_descriptor;
   endproperty
   a_part_src: assert property (p_part_src) // see R7
      else $error("partition source used without stage 1");

   property p_stalld_illegal;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && s1_on && stream_table_entry[STALLD_BIT]
         && stall_model_cap != STALL_NONE |=> bad_entry_error;
   endproperty
   a_stalld_illegal: assert property (p_stalld_illegal) // see R9
      else $error("stall disable not illegal");

   property p_secure_off;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && secure_entry
         |=> translation_service_enable == TSE_OFF;
   endproperty
   a_secure_off: assert property (p_secure_off) // see R20
      else $error("secure entry enable not zero");

   property p_check_off_bypass;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && !translated_traffic_check && is_translated_traffic
         && !illegal_c |=> traffic_bypass && !traffic_abort;
   endproperty
   a_check_off_bypass: assert property (p_check_off_bypass) // see R22
      else $error("traffic not bypassed with check off");

   property p_split_needs_nested;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && service_cap && !secure_entry
         && config_val[1:0] != 2'h0
         && stream_table_entry[TSE_HI:TSE_LO] == TSE_SPLIT
         && config_val != CFG_NESTED |=> bad_entry_error;
   endproperty
   a_split_needs_nested: assert property (p_split_needs_nested) // see R15
      else $error("split enable not illegal");

   property p_req_ur;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && is_trans_request && tse_eff == TSE_OFF
         && !illegal_c |=> request_unsupported;
   endproperty
   a_req_ur: assert property (p_req_ur) // see R11
      else $error("request not refused");

   property p_full_stall;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && tse_live && s2_on && stage2_stall_bit
         && stream_table_entry[TSE_HI:TSE_LO] == TSE_FULL
         |=> bad_entry_error;
   endproperty
   a_full_stall: assert property (p_full_stall) // see R13
      else $error("full enable with stage 2 stall not illegal");

   property p_world_el1;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && tse_live && per_granule_check_cap && !world_is_el1
         && stream_table_entry[TSE_HI:TSE_LO] == TSE_CHECK
         |=> bad_entry_error;
   endproperty
   a_world_el1: assert property (p_world_el1) // see R18
      else $error("checked enable outside el1 not illegal");

   property p_check_no_cap;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && tse_live && !per_granule_check_cap
         && stream_table_entry[TSE_HI:TSE_LO] == TSE_CHECK
         |=> translation_service_enable == TSE_OFF;
   endproperty
   a_check_no_cap: assert property (p_check_no_cap) // see R19
      else $error("checked enable without capability not zero");

   property p_split_check_off;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && !translated_traffic_check
         && stream_table_entry[TSE_HI:TSE_LO] == TSE_SPLIT
         |=> translation_service_enable == TSE_OFF;
   endproperty
   a_split_check_off: assert property (p_split_check_off) // see R16
      else $error("split enable with check off not zero");

   property p_split_no_bypass;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && is_translated_traffic && tse_eff == TSE_SPLIT
         |=> !traffic_bypass;
   endproperty
   a_split_no_bypass: assert property (p_split_no_bypass) // see R14
      else $error("split traffic bypassed");

   property p_pie_off;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && !stream_table_entry[PIE_BIT]
         |=> !stage1_perm_indirect_en;
   endproperty
   a_pie_off: assert property (p_pie_off) // see R2
      else $error("permission indirection enabled with bit clear");

   property p_silent_abort;
      @(posedge clock) disable iff (!rst_n)
         lookup_valid && config_val == CFG_ABORT
         |=> !bad_request_event && !forbidden_translation_event;
   endproperty
   a_silent_abort: assert property (p_silent_abort) // see R21
      else $error("event recorded for aborting config");
endmodule

// file: verif/pcie_endpoint_model.sv
// endpoint model issuing translation requests or translated traffic
`timescale 1ns/1ps
module pcie_endpoint_model (
   // reset
   input  wire logic       rst_n,
   // choice from the bench: 1 request, 2 translated, else idle
   input  wire logic [1:0] kind,
   // request kind toward the decoder
   output logic            is_trans_request,
   output logic            is_translated_traffic
);
   // one kind per lookup; an endpoint never marks both at once
   assign is_trans_request      = rst_n & (kind == 2'h1);
   assign is_translated_traffic = rst_n & (kind == 2'h2);
endmodule

// file: verif/ste_ctrl_decode_tb.sv
// self-checking bench for the stream entry control slice decoder
`timescale 1ns/1ps
module ste_ctrl_decode_tb
   import ste_ctrl_pkg::*;
;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   typedef struct packed {
      logic [ENTRY_W-1:0] e;
      logic [2:0]         c;
      logic               b, s2, f, sc, w, pc;
      logic [1:0]         sm, k;
      logic               sv, n1, gc, ck;
   } stim_t;
   logic        clock = 1'b0;
   logic        rst_n;
   logic        lv;
   stim_t       cur;
   logic        rq, tt;
   logic        o_pie, o_fwb, o_part, o_stalld, o_valid, o_bad;
   logic [1:0]  o_tse;
   logic [4:0]  o_ev;
   logic [12:0] got, x, m;
   int          seed, i, cycles, fail_count, n_checks;
   always #10 clock = ~clock;
   assign got = {o_valid, o_bad, o_pie, o_fwb, o_part, o_stalld, o_tse, o_ev};
   pcie_endpoint_model pcie_endpoint_model_inst (
      .rst_n(rst_n), .kind(cur.k),
      .is_trans_request(rq), .is_translated_traffic(tt));
   ste_ctrl_decode ste_ctrl_decode_inst (
      .clock(clock), .rst_n(rst_n), .lookup_valid(lv),
      .stream_table_entry(cur.e), .config_val(cur.c),
      .substream_bypass(cur.b), .stage2_stall_bit(cur.s2),
      .stage2_table_format_sel(cur.f), .secure_entry(cur.sc),
      .world_is_el1(cur.w), .perm_indirect_cap(cur.pc),
      .stall_model_cap(cur.sm), .service_cap(cur.sv),
      .no_stage1_service_cap(cur.n1), .per_granule_check_cap(cur.gc),
      .translated_traffic_check(cur.ck), .is_trans_request(rq),
      .is_translated_traffic(tt), .decode_valid(o_valid),
      .bad_entry_error(o_bad), .stage1_perm_indirect_en(o_pie),
      .stage2_forced_writeback(o_fwb),
      .partition_from_descriptor(o_part),
      .stage1_stall_disable(o_stalld),
      .translation_service_enable(o_tse),
      .request_unsupported(o_ev[4]), .bad_request_event(o_ev[3]),
      .traffic_abort(o_ev[2]), .forbidden_translation_event(o_ev[1]),
      .traffic_bypass(o_ev[0]));
   // ----------------------------------------
   // reference: {mask, value}; fields unchecked on a bad entry
   // ----------------------------------------
   function automatic logic [25:0] model(input stim_t s);
      logic       s1, s2on, ign, bad, sil, req, trn;
      logic [1:0] r, eff;
      logic [4:0] ev;
      s1   = s.c[2] & s.c[0] & !s.b;
      s2on = s.c[2] & s.c[1];
      ign  = s.sc | !s.sv | (s.c[1:0] == 2'h0);
      r    = s.e[TSE_HI:TSE_LO];
      sil  = (s.c == CFG_ABORT);
      req  = (s.k == 2'h1);
      trn  = (s.k == 2'h2);
      bad  = (s2on & s.e[FWB_BIT] & !s.f)
           | (s1 & s.e[STALLD_BIT] & (s.sm != STALL_CFG))
           | (!ign & ((((r == TSE_FULL) | ((r == TSE_CHECK) & s.gc))
                       & s2on & s.s2)
           | ((r == TSE_SPLIT) & ((s.c != CFG_NESTED) | s.s2 | s.n1))
           | ((r == TSE_CHECK) & s.gc & !s.w)));
      eff  = ign ? TSE_OFF : r;
      if ((eff == TSE_SPLIT && !s.ck) ||
          (eff == TSE_CHECK && (!s.gc || !s.ck))) begin
         eff = TSE_OFF;
      end
      ev[4] = req & (eff == TSE_OFF);
      ev[3] = ev[4] & !sil;
      ev[2] = trn & s.ck & (eff == TSE_OFF);
      ev[1] = ev[2] & !sil;
      ev[0] = trn & (!s.ck | eff == TSE_FULL | eff == TSE_CHECK);
      if (bad) begin
         ev = 5'h0;
      end
      return {bad ? 13'h181f : 13'h1fff,
              1'b1, bad, s.e[PIE_BIT] & s.pc & s1, s.e[FWB_BIT] & s2on,
              s.e[PART_SRC_BIT] & s1, s.e[STALLD_BIT] & s1, eff, ev};
   endfunction
   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [12:0] ex, mk);
      n_checks++;
      if ((got & mk) !== (ex & mk)) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, ex & mk, got & mk);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ceiling well above the 800 loop cycles plus reset
   always @(posedge clock) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 27131;
      rst_n = 1'b0;
      cur = '0;
      lv = 1'b0;
      repeat (3) @(posedge clock);
      #2 check("reset", 13'h0, 13'h1fff);
      rst_n = 1'b1;
      for (i = 0; i < 800; i++) begin
         @(posedge clock);
         #2;
         {m, x} = lv ? model(cur) : {13'h181f, 13'h0};
         check("decode", x, m);
         cur.e = {$random(seed), $random(seed), $random(seed), $random(seed)};
         {cur.c, cur.b, cur.s2, cur.f, cur.w, cur.pc} = $random(seed);
         {cur.sm, cur.k, cur.n1, cur.gc, cur.ck} = $random(seed);
         cur.sc = ($random(seed) & 7) == 0;
         cur.sv = ($random(seed) & 7) != 0;
         lv = ($random(seed) & 7) != 0;
         // pcie stream: software sets stall disable when configurable
         if (cur.sm == STALL_CFG) begin
            cur.e[STALLD_BIT] = 1'b1;
         end
         // every eighth cycle: nested entry, no stage 2 stall, no no-stage1 cap, all four enables
         if (i % 8 == 0) begin
            {cur.c, cur.s2, cur.n1, cur.sc, cur.sv} = {CFG_NESTED, 4'h1};
            cur.e[TSE_HI:TSE_LO] = i[4:3];
         end
      end
      report_and_stop();
   end
endmodule
